// ---- sim/uhd_disable_seq_asserts.sv ----
`include "uhd_cfg.svh"
module uhd_disable_seq_asserts #(
   parameter int unsigned WAIT_CYCLES = 10
) (
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [31:0]           paddr,
   input wire logic [31:0]           pwdata,
   input wire logic                  pready,
   input wire logic [31:0]           prdata,
   input wire logic                  pslverr,
   input wire logic                  xact_busy,
   input wire logic [1:0]            bus_line_state,
   input wire uhd_pkg::uhd_xcvr_type xcvr_out,
   input wire logic [2:0]            host_state_monitor,
   input wire logic                  disconnect_detect_en,
   input wire logic                  irq
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int WE = WAIT_CYCLES;
   wire logic [1:0] opm = xcvr_out.transceiver_op_mode;
   wire logic       wr_acc = psel && penable && pready && pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // only a sequencer-driven power-down counts; disconnect detection is off then
   sequence pd_entry;
      opm == `UHD_OPM_PWRDN && $past(opm) != `UHD_OPM_PWRDN && !disconnect_detect_en;
   endsequence
   chk_go_accept: assert property (
      wr_acc && paddr == `UHD_OFS_CMD && pwdata[2:0] == `UHD_CMD_GO_DIS && disconnect_detect_en
      |=> host_state_monitor == `UHD_HST_DISABLED && !disconnect_detect_en) else $error("go not taken");
   chk_disc_off: assert property (
      $fell(disconnect_detect_en) |=> !disconnect_detect_en [*8]) else $error("detect back too soon");
   chk_disc_wait: assert property (
      pd_entry |-> ##WE !disconnect_detect_en ##1 disconnect_detect_en) else $error("wait length wrong");
   chk_hs_to_fs: assert property (
      $changed(xcvr_out.port_speed_a) && !disconnect_detect_en |-> $past(xcvr_out.port_speed_a) == `UHD_SPD_HS
      && xcvr_out.port_speed_a == `UHD_SPD_FS && xcvr_out.transceiver_select == `UHD_SPD_FS
      && xcvr_out.termination_select == `UHD_TERM_FS ##1 opm == `UHD_OPM_PWRDN) else $error("bad fs switch");
   chk_keep_speed: assert property (
      pd_entry |-> $stable(xcvr_out.port_speed_a) && $stable(xcvr_out.transceiver_select)
      && $stable(xcvr_out.termination_select)) else $error("speed moved at power-down");
   chk_wait_xact: assert property (
      !disconnect_detect_en && xact_busy |=> $stable(xcvr_out)) else $error("moved during transaction");
   chk_irq_sticky: assert property (
      irq && !(psel && pwrite && (paddr == `UHD_OFS_INT_CLR || paddr == `UHD_OFS_INT_EN)) |=> irq)
      else $error("irq dropped");
   chk_irq_clear: assert property (
      wr_acc && paddr == `UHD_OFS_INT_CLR && pwdata[0] && disconnect_detect_en |=> !irq) else $error("no clear");
   chk_apb_ready: assert property (
      psel && !penable |=> pready ##1 !pready) else $error("ready timing");
   chk_apb_unmapped: assert property (
      psel && !penable && paddr == 32'h40 |=> pslverr && prdata == 32'h0) else $error("unmapped answer");
   cover property (pd_entry);
   cover property ($rose(irq));
   cover property ($fell(disconnect_detect_en) ##1 xact_busy);
endmodule

bind uhd_disable_seq uhd_disable_seq_asserts #(.WAIT_CYCLES(WAIT_CYCLES)) uhd_disable_seq_asserts_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .xact_busy(xact_busy),
   .bus_line_state(bus_line_state), .xcvr_out(xcvr_out), .host_state_monitor(host_state_monitor),
   .disconnect_detect_en(disconnect_detect_en), .irq(irq));

// ---- sim/uhd_periph_model.sv ----
`include "uhd_cfg.svh"
module uhd_periph_model #(
   parameter int SUSP_CYC = 8
) (
   input  wire logic       pclk,
   input  wire logic       go,
   input  wire logic [7:0] len,
   input  wire logic [1:0] opm,
   output logic            xact_busy,
   output logic [1:0]      line_state,
   output logic            suspended
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   int idle = 0;
   always @(posedge pclk) begin
      if (go)
         cnt <= len;
      else if (cnt > 0)
         cnt <= cnt - 1;
      idle <= (opm == `UHD_OPM_PWRDN) ? idle + 1 : 0;
   end
   assign xact_busy = cnt > 0;
   // idle bus rests at j; traffic toggles so stale values cannot pass
   assign line_state = xact_busy ? {cnt[0], ~cnt[0]} : 2'h1;
   // threshold scaled to the shortened wait, below the done point
   assign suspended = idle >= SUSP_CYC;
endmodule

// ---- sim/usb_host_port_disable_sequencer_test.sv ----
`include "uhd_cfg.svh"
module usb_host_port_disable_sequencer_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int W = 10;
   logic                  pclk = 1'b0;
   logic                  presetn = 1'b0;
   logic                  psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
   logic                  pready, pslverr, irq, dde, xbusy, susp, qe;
   logic [31:0]           paddr = 32'h0, pwdata = 32'h0, prdata, q, seed = 32'h00010e71;
   logic [7:0]            len = 8'h1;
   logic [1:0]            line, spd, s2;
   logic [2:0]            hst;
   uhd_pkg::uhd_xcvr_type xo;
   int                    n_fail = 0, checked = 0, m;

   uhd_disable_seq #(.WAIT_CYCLES(W)) uhd_disable_seq_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .xact_busy(xbusy), .bus_line_state(line), .xcvr_out(xo), .host_state_monitor(hst),
      .disconnect_detect_en(dde), .irq(irq));
   uhd_periph_model #(.SUSP_CYC(8)) uhd_periph_model_i (.pclk(pclk), .go(go), .len(len),
      .opm(xo.transceiver_op_mode), .xact_busy(xbusy), .line_state(line), .suspended(susp));

   always #25 pclk = ~pclk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      qe = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic cmp_pin(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic cmp_reg(input logic [31:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      cmp_pin(q, exp, "read");
   endtask

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (3000) @(posedge pclk);
      n_fail++;
      $display("ERROR %0t run hung", $time);
      complete_run;
   end

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      // the line state needs its two synchroniser flops before it reads back
      repeat (2) @(posedge pclk);
      cmp_reg(`UHD_OFS_STATE, 32'h114);
      cmp_reg(`UHD_OFS_XCVR, 32'h0);
      cmp_pin(qe, 1'b0, "no error");
      cmp_reg(32'h40, 32'h0);
      cmp_pin(qe, 1'b1, "error");
      // last pass repeats high speed with the interrupt masked
      for (int i = 0; i < 4; i++) begin
         spd = (i == 3) ? `UHD_SPD_HS : i[1:0];
         s2 = (spd == `UHD_SPD_HS) ? `UHD_SPD_FS : spd;
         apb(1'b1, `UHD_OFS_INT_EN, {31'h0, i != 3});
         apb(1'b1, `UHD_OFS_XCVR, {22'h0, spd, 4'h0, 1'b0, spd != `UHD_SPD_HS, spd});
         seed = lfsr(seed);
         len <= {5'h0, seed[2:0]} + 8'h1;
         go <= 1'b1;
         @(posedge pclk);
         go <= 1'b0;
         apb(1'b1, `UHD_OFS_CMD, {29'h0, `UHD_CMD_GO_DIS});
         @(posedge pclk);
         cmp_pin(hst, `UHD_HST_DISABLED, "state");
         cmp_pin(dde, 1'b0, "detect off");
         while (xo.transceiver_op_mode !== `UHD_OPM_PWRDN) @(posedge pclk);
         cmp_pin(xbusy, 1'b0, "transaction");
         cmp_pin(xo, {s2, `UHD_OPM_PWRDN, 1'b1, s2}, "xcvr");
         cmp_pin(susp, 1'b0, "awake");
         m = 0;
         do begin
            @(posedge pclk);
            m++;
         end while (dde !== 1'b1);
         cmp_pin(m, W + 1, "wait");
         cmp_pin(irq, i != 3, "irq");
         cmp_pin(susp, 1'b1, "suspend");
         cmp_reg(`UHD_OFS_INT_STAT, 32'h1);
         cmp_reg(`UHD_OFS_STATE, 32'h112);
         apb(1'b1, `UHD_OFS_INT_CLR, 32'h1);
         cmp_reg(`UHD_OFS_INT_STAT, 32'h0);
      end
      complete_run;
   end
endmodule

// ---- src/uhd_cfg.svh ----
`ifndef UHD_CFG_SVH
`define UHD_CFG_SVH

// register byte offsets
`define UHD_OFS_CMD        8'h00
`define UHD_OFS_STATE      8'h04
`define UHD_OFS_XCVR       8'h08
`define UHD_OFS_INT_STAT   8'h0c
`define UHD_OFS_INT_CLR    8'h10
`define UHD_OFS_INT_EN     8'h14
`define UHD_ADDR_W         8

// host state change command codes
`define UHD_CMD_NONE       3'h0
`define UHD_CMD_GO_DIS     3'h3
`define UHD_CMD_LSB        0
`define UHD_CMD_W          3

// host state monitor codes
`define UHD_HST_IDLE       3'h0
`define UHD_HST_WAIT_CONN  3'h1
`define UHD_HST_DISABLED   3'h2
`define UHD_HST_RESET      3'h3
`define UHD_HST_OPER       3'h4

// speed codes shared by transceiver_select and port_speed_a
`define UHD_SPD_HS         2'h0
`define UHD_SPD_FS         2'h1
`define UHD_SPD_LS         2'h2

// transceiver operating modes
`define UHD_OPM_NORMAL     2'h0
`define UHD_OPM_NONDRIVE   2'h1
`define UHD_OPM_PWRDN      2'h2

// termination select: 1 selects full-speed termination
`define UHD_TERM_HS        1'b0
`define UHD_TERM_FS        1'b1

// field positions
`define UHD_XCVR_SEL_LSB   0
`define UHD_XCVR_TERM_BIT  2
`define UHD_XCVR_OPM_LSB   4
`define UHD_XCVR_SPD_LSB   8
`define UHD_STATE_HST_LSB  0
`define UHD_STATE_DISC_BIT 4
`define UHD_STATE_BUSY_BIT 5
`define UHD_STATE_LINE_LSB 8
`define UHD_INT_DONE_BIT   0

// reset values
`define UHD_RST_HST        3'h4
`define UHD_RST_XCVR_SEL   2'h0
`define UHD_RST_TERM       1'b0
`define UHD_RST_OPM        2'h0
`define UHD_RST_SPD        2'h0
`define UHD_RST_DISC_EN    1'b1

// timing
`define UHD_CLK_KHZ        20000
`define UHD_DIS_WAIT_US    4000
`define UHD_DIS_WAIT_CYC   ((`UHD_DIS_WAIT_US * `UHD_CLK_KHZ + 999) / 1000)

`endif

// ---- src/uhd_disable_seq.sv ----
// Register access over APB and the placing of the registers were left to the implementer.
`include "uhd_cfg.svh"

// Overview of operation
// - firmware writes go-disabled command; hardware then runs the whole sequence alone
// - on acceptance the host state monitor switches to the disabled code
// - on acceptance disconnect detection turns off and stays off until the wait after power-down has run out
// - high speed: after transaction ends, select full speed, then power down
// - full/low speed: after transaction ends, only power down the transceiver
// - disconnect detection returns no earlier than 4 ms after power-down
// - completion flag sets together with disconnect detection re-enable
module uhd_disable_seq #(
   parameter int unsigned WAIT_CYCLES = `UHD_DIS_WAIT_CYC,
   parameter int unsigned CNT_W       = 20
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [31:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      pslverr,
   input  wire logic                 xact_busy,
   input  wire logic [1:0]           bus_line_state,
   output uhd_pkg::uhd_xcvr_type     xcvr_out,
   output logic [2:0]                host_state_monitor,
   output logic                      disconnect_detect_en,
   output logic                      irq
);

   // 2**CNT_W must stay inside int, and the terminal count must be reachable
   generate
      if (WAIT_CYCLES < 1) begin : g_bad_wait
         $error("uhd_disable_seq: WAIT_CYCLES must be at least one");
      end
      if (CNT_W < 1 || CNT_W > 30) begin : g_bad_width
         $error("uhd_disable_seq: CNT_W must lie between 1 and 30");
      end else if (WAIT_CYCLES > (2 ** CNT_W) - 1) begin : g_bad_fit
         $error("uhd_disable_seq: WAIT_CYCLES does not fit the counter");
      end
   endgenerate

   // terminal count at counter width; the checks above keep it from being cut
   localparam logic [CNT_W-1:0] WAIT_TERM = CNT_W'(WAIT_CYCLES);

   uhd_pkg::uhd_seq_type  seq_r;
   uhd_pkg::uhd_xcvr_type xcvr_r;
   logic [2:0]            cmd_r;
   logic [2:0]            hst_r;
   logic                  disc_en_r;
   logic [CNT_W-1:0]      cnt_r;
   logic                  done_stat_r;
   logic                  done_en_r;
   logic                  irq_r;
   logic                  pready_r;
   logic                  pslverr_r;
   logic [31:0]           prdata_r;
   logic [1:0]            line_meta_r;
   logic [1:0]            line_sync_r;

   logic                  wr_access;
   logic                  setup_ph;
   logic [`UHD_ADDR_W-1:0] addr;
   logic                  addr_ok;
   logic                  go_disabled_cmd;
   logic                  done_set;
   logic                  done_clr;
   logic                  done_stat_nxt;
   logic [31:0]           rd_nxt;

   // per-register strobes and sequencer conditions shared by several flops
   logic                  wr_cmd;
   logic                  wr_xcvr;
   logic                  wr_int_clr;
   logic                  wr_int_en;
   logic                  rd_setup;
   logic [`UHD_CMD_W-1:0] cmd_wdata;
   logic                  seq_busy;
   logic                  hs_attached;
   logic                  wait_done;
   logic                  done_en_nxt;
   logic                  irq_nxt;
   uhd_pkg::uhd_xcvr_type xcvr_wdata;

   assign addr     = paddr[`UHD_ADDR_W-1:0];
   assign setup_ph = psel && !penable;
   // a write lands only at the access edge that also samples pready high
   assign wr_access = psel && penable && pready_r && pwrite;

   assign wr_cmd     = wr_access && addr_ok && (addr == `UHD_OFS_CMD);
   assign wr_xcvr    = wr_access && addr_ok && (addr == `UHD_OFS_XCVR);
   assign wr_int_clr = wr_access && addr_ok && (addr == `UHD_OFS_INT_CLR);
   assign wr_int_en  = wr_access && addr_ok && (addr == `UHD_OFS_INT_EN);
   assign rd_setup   = setup_ph && !pwrite && addr_ok;
   assign cmd_wdata  = pwdata[`UHD_CMD_LSB +: `UHD_CMD_W];
   assign seq_busy   = (seq_r != uhd_pkg::SEQ_IDLE);
   // the speed in use comes from the port speed field; software sets it through the transceiver register
   assign hs_attached = (xcvr_r.port_speed_a == `UHD_SPD_HS);
   // the sequencer leaves SEQ_HOLD on the edge that sees the terminal count, so this is true for one edge only
   assign wait_done  = (seq_r == uhd_pkg::SEQ_HOLD) && (cnt_r == WAIT_TERM);

   always_comb begin
      case (addr)
         `UHD_OFS_CMD,
         `UHD_OFS_STATE,
         `UHD_OFS_XCVR,
         `UHD_OFS_INT_STAT,
         `UHD_OFS_INT_CLR,
         `UHD_OFS_INT_EN: addr_ok = (paddr[31:`UHD_ADDR_W] == '0);
         default:         addr_ok = 1'b0;
      endcase
   end

   // a go command is taken only when the sequencer is idle; others are stored, not acted on here
   assign go_disabled_cmd = wr_cmd && (cmd_wdata == `UHD_CMD_GO_DIS) && !seq_busy;

   // pready is set in the setup cycle, so every transfer takes exactly one access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
      end else begin
         pready_r <= setup_ph;
      end
   end

   // an unmapped address is refused with an error and never stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_r <= 1'b0;
      end else begin
         pslverr_r <= setup_ph && !addr_ok;
      end
   end

   // read data is built from the live fields; the busy bit reports a running sequence
   always_comb begin
      rd_nxt = '0;
      case (addr)
         `UHD_OFS_CMD: begin
            rd_nxt[`UHD_CMD_LSB +: `UHD_CMD_W] = cmd_r;
         end
         `UHD_OFS_STATE: begin
            rd_nxt[`UHD_STATE_HST_LSB +: 3]  = hst_r;
            rd_nxt[`UHD_STATE_DISC_BIT]      = disc_en_r;
            rd_nxt[`UHD_STATE_BUSY_BIT]      = seq_busy;
            rd_nxt[`UHD_STATE_LINE_LSB +: 2] = line_sync_r;
         end
         `UHD_OFS_XCVR: begin
            rd_nxt[`UHD_XCVR_SEL_LSB +: 2] = xcvr_r.transceiver_select;
            rd_nxt[`UHD_XCVR_TERM_BIT]     = xcvr_r.termination_select;
            rd_nxt[`UHD_XCVR_OPM_LSB +: 2] = xcvr_r.transceiver_op_mode;
            rd_nxt[`UHD_XCVR_SPD_LSB +: 2] = xcvr_r.port_speed_a;
         end
         `UHD_OFS_INT_STAT: begin
            rd_nxt[`UHD_INT_DONE_BIT] = done_stat_r;
         end
         `UHD_OFS_INT_EN: begin
            rd_nxt[`UHD_INT_DONE_BIT] = done_en_r;
         end
         default: begin
            rd_nxt = '0;
         end
      endcase
   end

   // read data is captured in the setup cycle and stands through the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= '0;
      end else if (rd_setup) begin
         prdata_r <= rd_nxt;
      end else if (setup_ph) begin
         prdata_r <= '0;
      end
   end

   // line state is a pin level: two flip-flops before anything reads it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_meta_r <= '0;
         line_sync_r <= '0;
      end else begin
         line_meta_r <= bus_line_state;
         line_sync_r <= line_meta_r;
      end
   end

   // the command field is stored even when busy; only an idle sequencer acts on it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_r <= `UHD_CMD_NONE;
      end else if (wr_cmd) begin
         cmd_r <= cmd_wdata;
      end
   end

   // one sequence at a time; a second go while busy is ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_r <= uhd_pkg::SEQ_IDLE;
      end else begin
         case (seq_r)
            uhd_pkg::SEQ_IDLE: begin
               if (go_disabled_cmd) begin
                  seq_r <= uhd_pkg::SEQ_WAIT_XACT;
               end
            end
            uhd_pkg::SEQ_WAIT_XACT: begin
               if (!xact_busy) begin
                  if (hs_attached) begin
                     seq_r <= uhd_pkg::SEQ_TO_FS;
                  end else begin
                     seq_r <= uhd_pkg::SEQ_PWRDN;
                  end
               end
            end
            uhd_pkg::SEQ_TO_FS: begin
               seq_r <= uhd_pkg::SEQ_PWRDN;
            end
            uhd_pkg::SEQ_PWRDN: begin
               seq_r <= uhd_pkg::SEQ_HOLD;
            end
            uhd_pkg::SEQ_HOLD: begin
               if (wait_done) begin
                  seq_r <= uhd_pkg::SEQ_IDLE;
               end
            end
            default: begin
               seq_r <= uhd_pkg::SEQ_IDLE;
            end
         endcase
      end
   end

   // the monitor changes on the same edge that accepts the command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hst_r <= `UHD_RST_HST;
      end else if (go_disabled_cmd) begin
         hst_r <= `UHD_HST_DISABLED;
      end
   end

   // counter clears on the power-down edge and runs on pclk; the exit edge is
   // WAIT_TERM + 1 cycles later, one past the rounded-up 4 ms so the bound is strict
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
      end else if (seq_r == uhd_pkg::SEQ_PWRDN) begin
         cnt_r <= '0;
      end else if (seq_r == uhd_pkg::SEQ_HOLD && cnt_r != WAIT_TERM) begin
         cnt_r <= cnt_r + CNT_W'(1);
      end
   end

   // detection stays off from acceptance until the wait has run out
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         disc_en_r <= `UHD_RST_DISC_EN;
      end else if (go_disabled_cmd) begin
         disc_en_r <= 1'b0;
      end else if (wait_done) begin
         disc_en_r <= 1'b1;
      end
   end

   // software view of the transceiver fields, unpacked from the write word
   always_comb begin
      xcvr_wdata                     = '0;
      xcvr_wdata.transceiver_select  = pwdata[`UHD_XCVR_SEL_LSB +: 2];
      xcvr_wdata.termination_select  = pwdata[`UHD_XCVR_TERM_BIT];
      xcvr_wdata.transceiver_op_mode = pwdata[`UHD_XCVR_OPM_LSB +: 2];
      xcvr_wdata.port_speed_a        = pwdata[`UHD_XCVR_SPD_LSB +: 2];
   end

   // software may rewrite the transceiver fields only while the sequencer is idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xcvr_r.transceiver_select  <= `UHD_RST_XCVR_SEL;
         xcvr_r.termination_select  <= `UHD_RST_TERM;
         xcvr_r.transceiver_op_mode <= `UHD_RST_OPM;
         xcvr_r.port_speed_a        <= `UHD_RST_SPD;
      end else if (seq_r == uhd_pkg::SEQ_TO_FS) begin
         xcvr_r.transceiver_select <= `UHD_SPD_FS;
         xcvr_r.termination_select <= `UHD_TERM_FS;
         xcvr_r.port_speed_a       <= `UHD_SPD_FS;
      end else if (seq_r == uhd_pkg::SEQ_PWRDN) begin
         xcvr_r.transceiver_op_mode <= `UHD_OPM_PWRDN;
      end else if (!seq_busy && !go_disabled_cmd && wr_xcvr) begin
         xcvr_r <= xcvr_wdata;
      end
   end

   assign done_set = wait_done;
   assign done_clr = wr_int_clr && pwdata[`UHD_INT_DONE_BIT];
   // a set in the same cycle as a clear wins, so no completion is lost
   assign done_stat_nxt = done_set || (done_stat_r && !done_clr);
   // an enable write acts on the same edge, so irq follows both next values
   assign done_en_nxt = wr_int_en ? pwdata[`UHD_INT_DONE_BIT] : done_en_r;
   assign irq_nxt     = done_stat_nxt && done_en_nxt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_stat_r <= 1'b0;
      end else begin
         done_stat_r <= done_stat_nxt;
      end
   end

   // the enable only gates the request; it never touches the status bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_en_r <= 1'b0;
      end else begin
         done_en_r <= done_en_nxt;
      end
   end

   // irq follows the next status so it rises on the same edge as the flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   // every output is a flop passed straight through
   assign pready               = pready_r;
   assign pslverr              = pslverr_r;
   assign prdata               = prdata_r;
   assign xcvr_out             = xcvr_r;
   assign host_state_monitor   = hst_r;
   assign disconnect_detect_en = disc_en_r;
   assign irq                  = irq_r;

endmodule

// ---- src/uhd_pkg.sv ----
package uhd_pkg;

   typedef struct packed {
      logic [1:0] port_speed_a;
      logic [1:0] transceiver_op_mode;
      logic       termination_select;
      logic [1:0] transceiver_select;
   } uhd_xcvr_type;

   typedef enum logic [2:0] {
      SEQ_IDLE,
      SEQ_WAIT_XACT,
      SEQ_TO_FS,
      SEQ_PWRDN,
      SEQ_HOLD
   } uhd_seq_type;

endpackage
